// [design/bsq_pkg.sv]
// package: register map, reset values, types and tables of the start-up sequencer
`default_nettype none
package bsq_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_PULSE  = 8'h04;
	localparam logic [7:0] REG_BRAKE  = 8'h08;
	localparam logic [7:0] REG_COAST  = 8'h0C;
	localparam logic [7:0] REG_ALIGN  = 8'h10;
	localparam logic [7:0] REG_SETTLE = 8'h14;
	localparam logic [7:0] REG_SPEED  = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1C;
	localparam logic [7:0] REG_MEAS   = 8'h20;
	localparam logic [7:0] REG_CURR0  = 8'h24;
	localparam logic [7:0] REG_CURR5  = 8'h38;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int CTRL_START  = 0;
	localparam int CTRL_FWD    = 1;
	localparam int CTRL_ALIGN  = 2;
	localparam int CTRL_ABORT  = 3;
	localparam int CTRL_ASTATE = 4;
	localparam int SPEED_GAIN  = 16;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic        RST_FWD    = 1'h1;
	localparam logic        RST_USEAL  = 1'h0;
	localparam logic [2:0]  RST_ASTATE = 3'h0;
	localparam logic [15:0] RST_PULSE  = 16'h00C8;
	localparam logic [15:0] RST_BRAKE  = 16'h0064;
	localparam logic [15:0] RST_COAST  = 16'h01F4;
	localparam logic [15:0] RST_ALIGN  = 16'hFFFF;
	localparam logic [15:0] RST_SETTLE = 16'h1000;
	localparam logic [15:0] RST_THR    = 16'h0010;
	localparam logic [7:0]  RST_GAIN   = 8'h10;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ       = 100;
	localparam int SPEED_WIN_US  = 10000;
	localparam int SPEED_WIN_CYC = SPEED_WIN_US * CLK_MHZ;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef logic [2:0] bsq_drive_t;
	typedef enum logic [3:0] {
		ST_IDLE   = 4'h0,
		ST_CHECK  = 4'h1,
		ST_WAIT   = 4'h2,
		ST_PULSE  = 4'h3,
		ST_BRAKE  = 4'h4,
		ST_COAST  = 4'h5,
		ST_DECIDE = 4'h6,
		ST_ALIGN  = 4'h7,
		ST_SETTLE = 4'h8
	} bsq_state_e;
	typedef struct packed {
		logic [2:0] hi;
		logic [2:0] lo;
	} bsq_gate_s;
	typedef struct packed {
		bsq_drive_t state;
		logic       closed;
		logic [7:0] duty;
	} bsq_handoff_s;
	// ------------------------------------------------------------
	// tables; phase A is bit 0, drive states AB AC BC BA CA CB
	// ------------------------------------------------------------
	localparam logic [2:0] HI_PHASE [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
	localparam logic [2:0] LO_PHASE [6] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};
	// opposite states back to back, so successive kicks cancel
	localparam bsq_drive_t PROBE_ORDER [6] = '{3'h0, 3'h3, 3'h1, 3'h4, 3'h2, 3'h5};
	localparam bsq_drive_t PATTERN_DRIVE [8] =
		'{3'h0, 3'h1, 3'h3, 3'h2, 3'h5, 3'h0, 3'h4, 3'h0};
endpackage
`default_nettype wire

// [design/bsq_bemf_speed.sv]
// module: back-EMF comparator speed, direction and standstill detector
`default_nettype none
module bsq_bemf_speed #(
	parameter int WIN_CYCLES = bsq_pkg::SPEED_WIN_CYC
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// comparator pins, phase A in bit 0
	input  wire logic [2:0]  cmpPin,
	// measurement
	output logic      [15:0] edgeCount,
	output logic             dirFwd,
	output logic             stopped,
	output logic             winDone,
	output logic      [2:0]  pattern
);
	localparam int WW = $clog2(WIN_CYCLES + 1);
	localparam logic [WW-1:0] WIN_LAST = WW'(WIN_CYCLES - 1);

	logic [2:0]    meta;
	logic [2:0]    cmp;
	logic [2:0]    cmpLast;
	logic [WW-1:0] winCnt;
	logic [15:0]   runCount;
	logic          fwdSeen;
	logic          aRise;

	assign aRise = cmp[0] & ~cmpLast[0];

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			meta    <= 3'h0;
			cmp     <= 3'h0;
			cmpLast <= 3'h0;
			pattern <= 3'h0;
		end else begin
			meta    <= cmpPin;
			cmp     <= meta;
			cmpLast <= cmp;
			pattern <= cmp;
		end
	end

	// one edge of phase A per electrical turn; B still low means forward
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			winCnt    <= '0;
			runCount  <= 16'h0000;
			fwdSeen   <= 1'h0;
			edgeCount <= 16'h0000;
			dirFwd    <= 1'h0;
			stopped   <= 1'h0;
			winDone   <= 1'h0;
		end else begin
			winDone <= 1'h0;
			if (winCnt == WIN_LAST) begin
				winCnt    <= '0;
				runCount  <= 16'h0000;
				edgeCount <= runCount;
				stopped   <= (runCount == 16'h0000);
				dirFwd    <= fwdSeen;
				winDone   <= 1'h1;
			end else begin
				winCnt <= winCnt + WW'(1);
				if (aRise && runCount != 16'hFFFF)
					runCount <= runCount + 16'h0001;
				if (aRise)
					fwdSeen <= ~cmp[1];
			end
		end
	end
endmodule
`default_nettype wire

// [design/bsq_startup_seq.sv]
// module: sensorless start-up sequencer with speed check, position probe and alignment
`default_nettype none
module bsq_startup_seq #(
	parameter int WIN_CYCLES = bsq_pkg::SPEED_WIN_CYC,
	parameter int AW         = 12
) (
	// clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	// register port
	input  wire logic [7:0]            regAddr,
	input  wire logic [31:0]           regWdata,
	input  wire logic                  regWr,
	input  wire logic                  regRd,
	output logic      [31:0]           regRdata,
	// back-EMF comparator pins
	input  wire logic [2:0]            bemfCmp,
	// gate driver
	output bsq_pkg::bsq_gate_s         gate,
	// current-sense converter
	output logic                       adcStart,
	output logic      [2:0]            adcPhase,
	input  wire logic                  adcDone,
	input  wire logic [AW-1:0]         adcData,
	// hand-over to open or closed loop
	output logic                       handoffValid,
	output bsq_pkg::bsq_handoff_s      handoff,
	output logic                       busy
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	bsq_pkg::bsq_state_e state;
	bsq_pkg::bsq_drive_t cfgAlignState;
	bsq_pkg::bsq_drive_t best;
	bsq_pkg::bsq_drive_t lower;
	bsq_pkg::bsq_drive_t upper;
	bsq_pkg::bsq_drive_t pick;
	logic          cfgFwd;
	logic          cfgUseAlign;
	logic [15:0]   cfgPulse;
	logic [15:0]   cfgBrake;
	logic [15:0]   cfgCoast;
	logic [15:0]   cfgAlign;
	logic [15:0]   cfgSettle;
	logic [15:0]   cfgThr;
	logic [7:0]    cfgGain;
	logic          startReq;
	logic          abortReq;
	logic [15:0]   tmr;
	logic          expire;
	logic [2:0]    idx;
	logic          armed;
	logic          captured;
	logic [AW-1:0] curr [6];
	logic [15:0]   edgeCount;
	logic          bemfFwd;
	logic          bemfStopped;
	logic          winDone;
	logic [2:0]    pattern;
	logic          fast;
	logic [23:0]   product;
	logic [7:0]    duty;
	logic          half;
	logic [2:0]    currIdx;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic bsq_pkg::bsq_gate_s gateOf(input bsq_pkg::bsq_drive_t d);
		bsq_pkg::bsq_gate_s g;
		g.hi = bsq_pkg::HI_PHASE[d];
		g.lo = bsq_pkg::LO_PHASE[d];
		return g;
	endfunction

	// k states forward or backward, modulo six
	function automatic bsq_pkg::bsq_drive_t stepDrive(
		input bsq_pkg::bsq_drive_t d,
		input logic [1:0]          k,
		input logic                fwd
	);
		logic [3:0] s;
		s = fwd ? {1'h0, d} + {2'h0, k} : {1'h0, d} + 4'h6 - {2'h0, k};
		if (s >= 4'h6)
			s = s - 4'h6;
		return s[2:0];
	endfunction

	// ------------------------------------------------------------
	// back-EMF speed measurement
	// ------------------------------------------------------------
	bsq_bemf_speed #(
		.WIN_CYCLES (WIN_CYCLES)
	) u_speed (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.cmpPin    (bemfCmp),
		.edgeCount (edgeCount),
		.dirFwd    (bemfFwd),
		.stopped   (bemfStopped),
		.winDone   (winDone),
		.pattern   (pattern)
	);

	assign fast    = edgeCount > cfgThr;
	// duty grows with speed; saturates rather than wrapping
	assign product = edgeCount * cfgGain;
	assign duty    = (product[23:16] != 8'h00) ? 8'hFF : product[15:8];

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	assign startReq = regWr && regAddr == bsq_pkg::REG_CTRL && regWdata[bsq_pkg::CTRL_START];
	assign abortReq = regWr && regAddr == bsq_pkg::REG_CTRL && regWdata[bsq_pkg::CTRL_ABORT];

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfgFwd        <= bsq_pkg::RST_FWD;
			cfgUseAlign   <= bsq_pkg::RST_USEAL;
			cfgAlignState <= bsq_pkg::RST_ASTATE;
			cfgPulse      <= bsq_pkg::RST_PULSE;
			cfgBrake      <= bsq_pkg::RST_BRAKE;
			cfgCoast      <= bsq_pkg::RST_COAST;
			cfgAlign      <= bsq_pkg::RST_ALIGN;
			cfgSettle     <= bsq_pkg::RST_SETTLE;
			cfgThr        <= bsq_pkg::RST_THR;
			cfgGain       <= bsq_pkg::RST_GAIN;
		end else if (regWr) begin
			case (regAddr)
				bsq_pkg::REG_CTRL: begin
					cfgFwd        <= regWdata[bsq_pkg::CTRL_FWD];
					cfgUseAlign   <= regWdata[bsq_pkg::CTRL_ALIGN];
					cfgAlignState <= regWdata[bsq_pkg::CTRL_ASTATE +: 3];
				end
				bsq_pkg::REG_PULSE:  cfgPulse  <= regWdata[15:0];
				bsq_pkg::REG_BRAKE:  cfgBrake  <= regWdata[15:0];
				bsq_pkg::REG_COAST:  cfgCoast  <= regWdata[15:0];
				bsq_pkg::REG_ALIGN:  cfgAlign  <= regWdata[15:0];
				bsq_pkg::REG_SETTLE: cfgSettle <= regWdata[15:0];
				bsq_pkg::REG_SPEED: begin
					cfgThr  <= regWdata[15:0];
					cfgGain <= regWdata[bsq_pkg::SPEED_GAIN +: 8];
				end
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// register reads, data in the cycle after the strobe only
	// ------------------------------------------------------------
	assign currIdx = 3'((regAddr - bsq_pkg::REG_CURR0) >> 2);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			regRdata <= 32'h0000_0000;
		end else if (!regRd) begin
			regRdata <= 32'h0000_0000;
		end else if (regAddr >= bsq_pkg::REG_CURR0 && regAddr <= bsq_pkg::REG_CURR5
				&& regAddr[1:0] == 2'h0) begin
			regRdata <= 32'(curr[currIdx]);
		end else begin
			case (regAddr)
				bsq_pkg::REG_CTRL: regRdata <= 32'({cfgAlignState, 1'h0, cfgUseAlign,
					cfgFwd, 1'h0});
				bsq_pkg::REG_PULSE:  regRdata <= {16'h0000, cfgPulse};
				bsq_pkg::REG_BRAKE:  regRdata <= {16'h0000, cfgBrake};
				bsq_pkg::REG_COAST:  regRdata <= {16'h0000, cfgCoast};
				bsq_pkg::REG_ALIGN:  regRdata <= {16'h0000, cfgAlign};
				bsq_pkg::REG_SETTLE: regRdata <= {16'h0000, cfgSettle};
				bsq_pkg::REG_SPEED:  regRdata <= {8'h00, cfgGain, cfgThr};
				bsq_pkg::REG_STATUS: regRdata <= {8'h00, handoff.duty, 7'h00,
					handoff.closed, handoff.state, busy, state};
				bsq_pkg::REG_MEAS:   regRdata <= {14'h0000, bemfStopped, bemfFwd, edgeCount};
				default:             regRdata <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// current capture, one slot per drive state
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 6; i++)
				curr[i] <= '0;
		end else if (state == bsq_pkg::ST_BRAKE && adcDone && !captured) begin
			curr[bsq_pkg::PROBE_ORDER[idx]] <= adcData;
		end
	end

	// ------------------------------------------------------------
	// position decision
	// ------------------------------------------------------------
	// highest current after a fixed pulse means the shortest rise time
	always_comb begin
		best = 3'h0;
		for (int i = 1; i < 6; i++)
			if (curr[i] > curr[best])
				best = 3'(i);
	end

	assign lower = stepDrive(best, 2'h1, 1'h0);
	assign upper = stepDrive(best, 2'h1, 1'h1);
	assign half  = curr[upper] > curr[lower];
	// rotor half nearer upper: 90 ahead lands on the second state forward, the first in reverse
	assign pick  = cfgFwd ? stepDrive(best, {1'h0, 1'h1} + {1'h0, half}, 1'h1)
		: stepDrive(best, 2'h2 - {1'h0, half}, 1'h0);

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	assign expire = tmr <= 16'h0001;
	assign busy   = state != bsq_pkg::ST_IDLE;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state        <= bsq_pkg::ST_IDLE;
			tmr          <= 16'h0000;
			idx          <= 3'h0;
			armed        <= 1'h0;
			captured     <= 1'h0;
			adcStart     <= 1'h0;
			adcPhase     <= 3'h0;
			gate         <= '0;
			handoffValid <= 1'h0;
			handoff      <= '0;
		end else begin
			adcStart     <= 1'h0;
			handoffValid <= 1'h0;
			if (tmr != 16'h0000)
				tmr <= tmr - 16'h0001;
			if (abortReq) begin
				state <= bsq_pkg::ST_IDLE;
				gate  <= '0;
			end else begin
				unique case (state)
					bsq_pkg::ST_IDLE: begin
						if (startReq) begin
							state <= bsq_pkg::ST_CHECK;
							armed <= 1'h0;
						end
					end
					// first window is partial, so its count is not trusted
					bsq_pkg::ST_CHECK: begin
						if (winDone) begin
							armed <= 1'h1;
							if (armed && fast && bemfFwd == cfgFwd) begin
								handoff.state  <= bsq_pkg::PATTERN_DRIVE[pattern];
								handoff.closed <= 1'h1;
								handoff.duty   <= duty;
								handoffValid   <= 1'h1;
								state          <= bsq_pkg::ST_IDLE;
							end else if (armed) begin
								state <= bsq_pkg::ST_WAIT;
							end
						end
					end
					bsq_pkg::ST_WAIT: begin
						if (winDone && bemfStopped) begin
							idx <= 3'h0;
							if (cfgUseAlign) begin
								state <= bsq_pkg::ST_ALIGN;
								tmr   <= cfgAlign;
								gate  <= gateOf(cfgAlignState);
							end else begin
								state <= bsq_pkg::ST_PULSE;
								tmr   <= cfgPulse;
								gate  <= gateOf(bsq_pkg::PROBE_ORDER[0]);
							end
						end
					end
					bsq_pkg::ST_PULSE: begin
						if (expire) begin
							gate.hi  <= 3'h0;
							adcStart <= 1'h1;
							adcPhase <= gate.lo;
							captured <= 1'h0;
							tmr      <= cfgBrake;
							state    <= bsq_pkg::ST_BRAKE;
						end
					end
					// coast waits for the sample as well as the brake time
					bsq_pkg::ST_BRAKE: begin
						if (adcDone)
							captured <= 1'h1;
						if (expire && (captured || adcDone)) begin
							gate.lo <= 3'h0;
							tmr     <= cfgCoast;
							state   <= bsq_pkg::ST_COAST;
						end
					end
					bsq_pkg::ST_COAST: begin
						if (expire) begin
							if (idx == 3'h5) begin
								state <= bsq_pkg::ST_DECIDE;
							end else begin
								idx   <= idx + 3'h1;
								tmr   <= cfgPulse;
								gate  <= gateOf(bsq_pkg::PROBE_ORDER[idx + 3'h1]);
								state <= bsq_pkg::ST_PULSE;
							end
						end
					end
					bsq_pkg::ST_DECIDE: begin
						handoff.state  <= pick;
						handoff.closed <= 1'h0;
						handoff.duty   <= 8'h00;
						handoffValid   <= 1'h1;
						state          <= bsq_pkg::ST_IDLE;
					end
					bsq_pkg::ST_ALIGN: begin
						if (expire) begin
							gate  <= '0;
							tmr   <= cfgSettle;
							state <= bsq_pkg::ST_SETTLE;
						end
					end
					bsq_pkg::ST_SETTLE: begin
						if (expire) begin
							handoff.state  <= stepDrive(cfgAlignState, 2'h1, cfgFwd);
							handoff.closed <= 1'h0;
							handoff.duty   <= 8'h00;
							handoffValid   <= 1'h1;
							state          <= bsq_pkg::ST_IDLE;
						end
					end
					default: begin
						state <= bsq_pkg::ST_IDLE;
						gate  <= '0;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	sequence s_pulseEnd;
		state == bsq_pkg::ST_PULSE && expire && !abortReq;
	endsequence
	sequence s_brakeOn;
		state == bsq_pkg::ST_BRAKE && adcStart && gate.hi == 3'h0 && $onehot(gate.lo);
	endsequence
	sequence s_coastLeft;
		state == bsq_pkg::ST_COAST && expire && idx != 3'h5 && !abortReq;
	endsequence

	AST_CHECK_FIRST: assert property (
		state == bsq_pkg::ST_IDLE && startReq && !abortReq |=> state == bsq_pkg::ST_CHECK)
		else $error("start did not enter speed check");
	AST_TAKEOVER: assert property (
		state == bsq_pkg::ST_CHECK && winDone && armed && fast && bemfFwd == cfgFwd
		&& !abortReq |=> handoffValid && handoff.closed && handoff.duty == $past(duty))
		else $error("spinning motor not taken over");
	AST_WAIT_STOP: assert property (
		state == bsq_pkg::ST_WAIT && !(winDone && bemfStopped) && !abortReq
		|=> state == bsq_pkg::ST_WAIT)
		else $error("left wait before motor stopped");
	AST_TWO_PHASES: assert property (
		state inside {bsq_pkg::ST_PULSE, bsq_pkg::ST_ALIGN} |-> $onehot(gate.hi)
		&& $onehot(gate.lo) && (gate.hi & gate.lo) == 3'h0)
		else $error("drive state not one high and one low");
	AST_ORDER: assert property (
		state == bsq_pkg::ST_PULSE |-> gate == gateOf(bsq_pkg::PROBE_ORDER[idx]))
		else $error("probe pulse out of order");
	AST_PULSE_LEN: assert property (
		state != bsq_pkg::ST_PULSE ##1 state == bsq_pkg::ST_PULSE |-> tmr == cfgPulse)
		else $error("pulse timer not loaded");
	AST_PULSE_ADC: assert property (
		s_pulseEnd |=> s_brakeOn and adcPhase == $past(gate.lo))
		else $error("pulse end did not brake and start conversion");
	AST_BRAKE_LOW: assert property (
		state == bsq_pkg::ST_BRAKE |-> gate.hi == 3'h0 && $onehot(gate.lo))
		else $error("brake without low side only");
	AST_COAST_OFF: assert property (
		state == bsq_pkg::ST_COAST |-> gate == '0)
		else $error("gates on while coasting");
	AST_COAST_HOLD: assert property (
		state == bsq_pkg::ST_COAST && !expire && !abortReq |=> state == bsq_pkg::ST_COAST)
		else $error("coast cut short");
	AST_NEXT_PULSE: assert property (
		s_coastLeft |=> state == bsq_pkg::ST_PULSE && idx == $past(idx) + 3'h1)
		else $error("next pulse not started after coast");
	AST_DECIDE: assert property (
		state == bsq_pkg::ST_DECIDE && !abortReq
		|=> handoffValid && !handoff.closed && handoff.state == $past(pick))
		else $error("probe result not handed over");
	AST_ALIGN_END: assert property (
		state == bsq_pkg::ST_ALIGN && expire && !abortReq
		|=> state == bsq_pkg::ST_SETTLE && gate == '0 && tmr == cfgSettle)
		else $error("alignment did not release and settle");
	AST_MODE_SEL: assert property (
		state == bsq_pkg::ST_WAIT && winDone && bemfStopped && !abortReq
		|=> state == ($past(cfgUseAlign) ? bsq_pkg::ST_ALIGN : bsq_pkg::ST_PULSE))
		else $error("wrong start-up mode chosen");
endmodule
`default_nettype wire

// [testbench/bsq_motor_model.sv]
// partner: bridge and motor model with back-EMF comparators and phase current
`default_nettype none
module bsq_motor_model (
	// gate drive and converter control
	input  wire bsq_pkg::bsq_gate_s gate,
	input  wire logic               sys_clk,
	input  wire logic               adcStart,
	// motion and current profile
	input  wire logic               spin,
	input  wire logic               rev,
	input  wire logic [71:0]        currTab,
	// sensed values
	output logic      [2:0]         bemfCmp,
	output logic                    adcDone,
	output logic      [11:0]        adcData
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [2:0] SEQ [6] = '{3'h5, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4};
	int step = 0;
	int lag  = 0;
	int drv  = 0;
	initial begin
		bemfCmp = 3'h0;
		adcDone = 1'b0;
		adcData = 12'h000;
	end
	always @(posedge sys_clk) begin
		step <= (step + 1) % 24;
		// a rotor at rest shows no back-EMF edges
		bemfCmp <= spin ? SEQ[rev ? 5 - step / 4 : step / 4] : 3'h0;
		for (int k = 0; k < 6; k++)
			if (gate.hi == bsq_pkg::HI_PHASE[k] && gate.lo == bsq_pkg::LO_PHASE[k]) drv <= k;
		adcDone <= 1'b0;
		// odd states convert slowly, even ones promptly
		if (adcStart) lag <= (drv & 1) ? 3 : 1;
		else if (lag > 0) begin
			lag <= lag - 1;
			adcDone <= lag == 1;
		end
		// outside a result the bus toggles so stale data never matches
		adcData <= (lag == 1) ? currTab[drv*12 +: 12] : ~adcData;
	end
endmodule
`default_nettype wire

// [testbench/bsq_startup_seq_bench.sv]
// testbench: self-checking bench of the start-up sequencer
`default_nettype none
module bsq_startup_seq_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  sys_clk = 0, rst = 1, regWr = 0, regRd = 0, spin = 0, rev = 0;
	logic                  adcDone, adcStart, handoffValid, busy;
	logic [7:0]            regAddr = 0;
	logic [31:0]           regWdata = 0, regRdata, rdv;
	logic [2:0]            bemfCmp, adcPhase, prevHi = 0;
	logic [11:0]           adcData;
	logic [71:0]           currTab = 0;
	bsq_pkg::bsq_gate_s    gate;
	bsq_pkg::bsq_handoff_s handoff;
	int                    nErrors = 0, nTests = 0, nSamp = 0, seed = 32'he21711b5;
	int                    order[$];
	localparam logic [7:0]  ADR [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h3C};
	localparam logic [31:0] RV [8] = '{32'h2, 32'hC8, 32'h64, 32'h1F4, 32'hFFFF, 32'h1000,
		32'h00100010, 32'h0};
	bsq_startup_seq #(.WIN_CYCLES(64), .AW(12)) DUT (.sys_clk(sys_clk), .rst(rst),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .bemfCmp(bemfCmp), .gate(gate), .adcStart(adcStart),
		.adcPhase(adcPhase), .adcDone(adcDone), .adcData(adcData),
		.handoffValid(handoffValid), .handoff(handoff), .busy(busy));
	bsq_motor_model motor (.sys_clk(sys_clk), .gate(gate), .adcStart(adcStart), .spin(spin),
		.rev(rev), .currTab(currTab), .bemfCmp(bemfCmp), .adcDone(adcDone), .adcData(adcData));
	always #5 sys_clk = ~sys_clk;
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			nErrors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge sys_clk);
		regWr <= 1;
		regAddr <= a;
		regWdata <= d;
		@(posedge sys_clk);
		regWr <= 0;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge sys_clk);
		regRd <= 1;
		regAddr <= a;
		@(posedge sys_clk);
		regRd <= 0;
		#1 rdv = regRdata;
	endtask
	task automatic waitHo();
		for (int i = 0; i < 3000 && handoffValid !== 1'b1; i++) @(posedge sys_clk) #1;
		chk("handoff pulse", handoffValid, 1);
	endtask
	task automatic finishTest();
		$display("checks %0d mismatches %0d", nTests, nErrors);
		if (nErrors == 0 && nTests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// brightest current means shortest rise; pick ninety degrees ahead
	function automatic int expProbe(logic [71:0] t, bit fwd);
		int m = 0;
		int h;
		for (int k = 1; k < 6; k++) if (t[k*12 +: 12] > t[m*12 +: 12]) m = k;
		h = t[((m + 1) % 6)*12 +: 12] > t[((m + 5) % 6)*12 +: 12];
		return fwd ? (m + 1 + h) % 6 : (m + 4 + h) % 6;
	endfunction
	// ------------------------------------------------------------
	// gate and converter monitor
	// ------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (adcStart === 1'b1) begin
			nSamp++;
			chk("high sides off at sample", gate.hi, 0);
			chk("sensed phase", adcPhase, gate.lo);
		end
		if (gate.hi !== 3'h0 && prevHi === 3'h0) begin
			chk("two phases", $countones(gate.hi) + 4 * $countones(gate.lo), 5);
			for (int k = 0; k < 6; k++)
				if (gate.hi === bsq_pkg::HI_PHASE[k] && gate.lo === bsq_pkg::LO_PHASE[k])
					order.push_back(k);
		end
		prevHi = gate.hi;
	end
	initial begin
		#400000;
		nErrors++;
		finishTest();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 0;
		for (int k = 0; k < 8; k++) begin
			rd(ADR[k]);
			chk("reset value", rdv, RV[k]);
		end
		$display("register test done");
		wr(8'h04, 3 + ($random(seed) & 3));
		wr(8'h08, 1);
		wr(8'h0C, 2);
		wr(8'h10, 5);
		wr(8'h14, 3);
		wr(8'h18, 32'h00FF0001);
		for (int f = 1; f >= 0; f--) begin
			for (int k = 0; k < 6; k++) currTab[k*12 +: 12] = ($random(seed) & 12'hFF0) | k;
			order.delete();
			nSamp = 0;
			wr(8'h00, {30'h0, f[0], 1'b1});
			waitHo();
			chk("probe state", handoff.state, expProbe(currTab, f[0]));
			chk("probe closed", handoff.closed, 0);
			chk("conversions", nSamp, 6);
			chk("pulses", order.size(), 6);
			for (int k = 0; k < 6; k++) chk("probe order", order[k], bsq_pkg::PROBE_ORDER[k]);
			$display("probe test done");
		end
		for (int a = 0; a < 6; a++) begin
			order.delete();
			wr(8'h00, {25'h0, a[2:0], 1'b0, 1'b1, a[0], 1'b1});
			waitHo();
			chk("aligned drive", order[0], a);
			chk("align state", handoff.state, a[0] ? (a + 1) % 6 : (a + 5) % 6);
		end
		$display("alignment test done");
		spin = 1;
		repeat (20) @(posedge sys_clk);
		wr(8'h00, 32'h3);
		waitHo();
		chk("takeover closed", handoff.closed, 1);
		chk("takeover state", handoff.state < 6, 1);
		rd(8'h20);
		chk("takeover dir", rdv[16], 1);
		chk("takeover duty", handoff.duty, (rdv[15:0] * 255) >> 8);
		$display("takeover test done");
		rev = 1;
		wr(8'h00, 32'h3);
		repeat (300) @(posedge sys_clk);
		chk("waits while reversed", busy, 1);
		spin = 0;
		waitHo();
		chk("restart from rest", handoff.closed, 0);
		chk("restart state", handoff.state, expProbe(currTab, 1));
		$display("reverse test done");
		wr(8'h00, 32'h3);
		repeat (180) @(posedge sys_clk);
		wr(8'h00, 32'hA);
		#1;
		chk("abort idle", busy, 0);
		chk("abort gates", gate, 0);
		$display("abort test done");
		finishTest();
	end
endmodule
`default_nettype wire
